// ==== logic/phy_id_pkg.sv ====
// shared constants and types for the phy identification and power-class register bank
package phy_id_pkg;
    // ****************************************************************
    // bus and register map
    // ****************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 4;
    localparam int unsigned IDX_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_PWR_CLASS = 4'h4;
    localparam logic [IDX_W-1:0] IDX_PAGE_SEL = 4'h7;
    localparam logic [IDX_W-1:0] IDX_COMPLIANCE = 4'h8;
    localparam logic [IDX_W-1:0] IDX_IDENT_RSVD = 4'h9;
    localparam logic [IDX_W-1:0] IDX_OUI_HI = 4'hA;
    localparam logic [IDX_W-1:0] IDX_OUI_MID = 4'hB;
    localparam logic [IDX_W-1:0] IDX_OUI_LO = 4'hC;
    localparam logic [IDX_W-1:0] IDX_PART_HI = 4'hD;
    localparam logic [IDX_W-1:0] IDX_PART_MID = 4'hE;
    localparam logic [IDX_W-1:0] IDX_PART_LO = 4'hF;
    localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 4'hE;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 8'h3C;

    // ****************************************************************
    // pages and fields
    // ****************************************************************
    localparam int unsigned PAGE_W = 3;
    localparam logic [PAGE_W-1:0] PAGE_IDENT = 3'h1;
    localparam logic [PAGE_W-1:0] PAGE_VENDOR = 3'h7;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
    localparam int unsigned SOFT_RESET_BIT = 0;
    localparam logic [7:0] COMPLIANCE_LEVEL = 8'h02;
    localparam int unsigned SELF_ID_PWR_LSB = 21;
    localparam int unsigned SELF_ID_PWR_MSB = 23;

    // ****************************************************************
    // power-class codes
    // ****************************************************************
    localparam int unsigned PWR_W = 3;
    localparam logic [PWR_W-1:0] PWR_NONE = 3'h0;
    localparam logic [PWR_W-1:0] PWR_SELF_15W = 3'h1;
    localparam logic [PWR_W-1:0] PWR_SELF_30W = 3'h2;
    localparam logic [PWR_W-1:0] PWR_SELF_45W = 3'h3;
    localparam logic [PWR_W-1:0] PWR_BUS_3W = 3'h4;
    localparam logic [PWR_W-1:0] PWR_RESERVED = 3'h5;
    localparam logic [PWR_W-1:0] PWR_BUS_PLUS_3W = 3'h6;
    localparam logic [PWR_W-1:0] PWR_BUS_PLUS_7W = 3'h7;
    localparam logic [3:0] EXTRA_W_NONE = 4'h0;
    localparam logic [3:0] EXTRA_W_3 = 4'h3;
    localparam logic [3:0] EXTRA_W_7 = 4'h7;

    // strap synchroniser depth before a value may be trusted
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    // ****************************************************************
    // apb request carrier
    // ****************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic allow;
        logic [PWR_W-1:0] code;
    } strap_t;
endpackage

// ==== logic/phy_id_pages_power_class.sv ====
// register bank: identification page, vendor page with soft hard reset, power-class default
// ****************************************************************
// Overview of operation
// [RULE1] page select value 1 maps identification page onto paged indices 8 to 15
// [RULE2] index 8 reads compliance level 02h; index 9 reserved
// [RULE3] maker oui read-only over indices 10..12, most significant byte first
// [RULE4] part code read-only over indices 13..15, most significant byte first
// [RULE5] page select value 7 maps vendor control and test page
// [RULE6] soft hard reset at bit 0 of index 14 on vendor page; rest reserved
// [RULE7] writing one to soft hard reset performs a complete hard reset
// [RULE8] soft hard reset bit always reads back as zero
// [RULE9] default power class comes from three strap pins, sent in self-id bits 21-23
// [RULE10] strap default loads after each reset; later register 4 write replaces it
// [RULE11] code 000 no power; 001/010/011 self-powered giving 15, 30, 45 W
// [RULE12] code 100 may be bus-powered, up to 3 W, no extra link power
// [RULE13] codes 110/111 bus-powered 3 W, link needs further 3 W or 7 W
// [RULE14] software must not program reserved power class code 101
// [RULE15] writes to read-only or reserved ignored; reserved reads return zero
// [RULE16] external reset held low 2 ms; soft reset reproduces its effect
// ****************************************************************
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module phy_id_pages_power_class #(
    parameter logic [23:0] MAKER_OUI = 24'h5A5A5A, // arbitrary value
    parameter logic [23:0] PART_CODE = 24'h0C0FFE, // arbitrary value
    parameter logic [2:0] PWR_NO_STRAP = 3'h0 // default when straps are not allowed
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rst_n, // synchronous reset, low active
    input wire phy_id_pkg::apb_req_t apb_req, // apb request signals
    output logic [phy_id_pkg::DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic power_strap_bit0, // strap pin, power class bit 0
    input wire logic power_strap_bit1, // strap pin, power class bit 1
    input wire logic power_strap_bit2, // strap pin, power class bit 2
    input wire logic strap_mode_allow, // pin: speed/mode selection allows straps
    output logic [2:0] self_id_pwr, // power class for self-id bits 21-23
    output logic pwr_self_powered, // node supplies power to the bus
    output logic pwr_bus_powered, // node may draw from the bus
    output logic [3:0] link_extra_watts, // extra watts needed to enable the link
    output logic soft_reset_pulse // one-cycle hard reset request from software
);
    import phy_id_pkg::*;

    // ****************************************************************
    // reset
    // ****************************************************************
    logic soft_reset_q;
    logic hard_rst;
    assign hard_rst = !rst_n || soft_reset_q; // [RULE7] [RULE16]

    // ****************************************************************
    // strap synchroniser, three stages
    // ****************************************************************
    strap_t strap_pin;
    strap_t sync1_q;
    strap_t sync2_q;
    strap_t sync3_q;
    logic [1:0] settle_q;
    logic strap_stable;
    assign strap_pin = '{allow: strap_mode_allow,
                         code: {power_strap_bit2, power_strap_bit1, power_strap_bit0}};
    // only the pin reset clears the chain, so a soft reset sees settled straps at once
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            settle_q <= '0;
        end else begin
            sync1_q <= strap_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (settle_q != SYNC_SETTLE) begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end
    assign strap_stable = (settle_q == SYNC_SETTLE) && (sync2_q == sync3_q);

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic [IDX_W-1:0] req_idx;
    logic req_mapped;
    logic wr_fire;
    logic pready_q;
    assign req_idx = apb_req.paddr[IDX_LSB+IDX_W-1:IDX_LSB];
    assign req_mapped = (apb_req.paddr <= ADDR_LAST) && (apb_req.paddr[IDX_LSB-1:0] == 2'h0);
    // writes land only at the edge where ready is sampled high
    assign wr_fire = apb_req.psel && apb_req.penable && pready_q && apb_req.pwrite && req_mapped;

    // ****************************************************************
    // page select and power class registers
    // ****************************************************************
    logic [PAGE_W-1:0] page_q;
    logic [PWR_W-1:0] pwr_q;
    logic load_pending_q;
    logic pwr_wr;
    assign pwr_wr = wr_fire && (req_idx == IDX_PWR_CLASS);
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            page_q <= PAGE_RESET;
        end else if (wr_fire && (req_idx == IDX_PAGE_SEL)) begin
            page_q <= apb_req.pwdata[PAGE_W-1:0];
        end
    end
    // strap default loads once after reset; a software write wins over the pending load
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            pwr_q <= PWR_NONE;
            load_pending_q <= 1'b1; // [RULE10]
        end else if (pwr_wr) begin
            pwr_q <= apb_req.pwdata[PWR_W-1:0]; // [RULE10] code 101 stored as written
            load_pending_q <= 1'b0;
        end else if (load_pending_q && strap_stable) begin
            pwr_q <= sync3_q.allow ? sync3_q.code : PWR_NO_STRAP; // [RULE9]
            load_pending_q <= 1'b0;
        end
    end

    // ****************************************************************
    // soft hard reset, self-clearing
    // ****************************************************************
    logic soft_reset_d;
    assign soft_reset_d = wr_fire && (page_q == PAGE_VENDOR) && (req_idx == IDX_SOFT_RESET)
                          && apb_req.pwdata[SOFT_RESET_BIT]; // [RULE6] [RULE7]
    // only the pin clears these, so the request cannot cancel itself mid-pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            soft_reset_q <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_q <= soft_reset_d; // [RULE7]
            soft_reset_pulse <= soft_reset_d; // [RULE7]
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00; // [RULE15] reserved and test bytes read zero
        if (req_idx == IDX_PWR_CLASS) begin
            rd_byte = {5'h00, pwr_q};
        end else if (req_idx == IDX_PAGE_SEL) begin
            rd_byte = {5'h00, page_q};
        end else if (page_q == PAGE_IDENT) begin // [RULE1]
            case (req_idx)
                IDX_COMPLIANCE: rd_byte = COMPLIANCE_LEVEL; // [RULE2]
                IDX_OUI_HI: rd_byte = MAKER_OUI[23:16]; // [RULE3]
                IDX_OUI_MID: rd_byte = MAKER_OUI[15:8]; // [RULE3]
                IDX_OUI_LO: rd_byte = MAKER_OUI[7:0]; // [RULE3]
                IDX_PART_HI: rd_byte = PART_CODE[23:16]; // [RULE4]
                IDX_PART_MID: rd_byte = PART_CODE[15:8]; // [RULE4]
                IDX_PART_LO: rd_byte = PART_CODE[7:0]; // [RULE4]
                default: rd_byte = 8'h00;
            endcase
        end else if (page_q == PAGE_VENDOR) begin
            rd_byte = 8'h00; // [RULE5] [RULE8] soft reset bit reads zero
        end
    end

    // ****************************************************************
    // apb answer: one wait-free access cycle after setup
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            pready_q <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (apb_req.psel && !apb_req.penable) begin
            pready_q <= 1'b1;
            pslverr <= !req_mapped;
            prdata <= (!apb_req.pwrite && req_mapped) ? {24'h000000, rd_byte} : '0;
        end else begin
            pready_q <= 1'b0;
            pslverr <= 1'b0;
        end
    end
    assign pready = pready_q;

    // ****************************************************************
    // power class outputs and decode
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            self_id_pwr <= PWR_NONE;
            pwr_self_powered <= 1'b0;
            pwr_bus_powered <= 1'b0;
            link_extra_watts <= EXTRA_W_NONE;
        end else begin
            self_id_pwr <= pwr_q; // [RULE9]
            pwr_self_powered <= (pwr_q == PWR_SELF_15W) || (pwr_q == PWR_SELF_30W)
                                || (pwr_q == PWR_SELF_45W); // [RULE11]
            pwr_bus_powered <= (pwr_q == PWR_BUS_3W) || (pwr_q == PWR_BUS_PLUS_3W)
                               || (pwr_q == PWR_BUS_PLUS_7W); // [RULE12] [RULE13]
            case (pwr_q)
                PWR_BUS_PLUS_3W: link_extra_watts <= EXTRA_W_3; // [RULE13]
                PWR_BUS_PLUS_7W: link_extra_watts <= EXTRA_W_7; // [RULE13]
                default: link_extra_watts <= EXTRA_W_NONE; // [RULE12]
            endcase
        end
    end
endmodule // phy_id_pages_power_class

`default_nettype wire

// ==== sim/apb_host_model.sv ====
// apb master model standing in for the link-layer controller
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    input wire logic ref_clk, // bus clock
    output var phy_id_pkg::apb_req_t req, // request to the bank
    input wire logic pready, // ready from the bank
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr // error flag
);
    import phy_id_pkg::*;
    initial req = '0;
    // setup, then access held until ready is sampled high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // released lines carry junk so nothing leans on stale values
        req <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask
endmodule // apb_host_model
`default_nettype wire

// ==== sim/phy_id_chk.sv ====
// assertion checker for the identification and power-class register bank
`timescale 1ns/1ps
`default_nettype none
module phy_id_chk #(
    parameter logic [23:0] MAKER_OUI = 24'h0, // from the bound design
    parameter logic [23:0] PART_CODE = 24'h0 // from the bound design
) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // sync reset
    input wire phy_id_pkg::apb_req_t apb_req, // apb request
    input wire logic [phy_id_pkg::DATA_W-1:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [2:0] self_id_pwr, // power class
    input wire logic pwr_self_powered, // self powered flag
    input wire logic pwr_bus_powered, // bus powered flag
    input wire logic [3:0] link_extra_watts, // link watts
    input wire logic soft_reset_pulse // soft reset request
);
    import phy_id_pkg::*;
    logic [2:0] page_q;
    logic [2:0] code_q;
    logic [7:0] id_byte;
    wire wr_done = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    wire bad_addr = apb_req.paddr > ADDR_LAST || apb_req.paddr[1:0] != 2'h0;
    always_comb id_byte = 8'({MAKER_OUI, PART_CODE} >> (8 * (5 - (apb_req.paddr - 8'h28) / 4)));
    // page as written over the bus; soft reset clears it like the pin
    always_ff @(posedge ref_clk) begin
        if (!rst_n) page_q <= 3'h0;
        else if (wr_done && apb_req.paddr == 8'h1C) page_q <= apb_req.pwdata[2:0];
        else if (wr_done && apb_req.paddr == 8'h38 && page_q == PAGE_VENDOR && apb_req.pwdata[0])
            page_q <= 3'h0;
    end
    // last power class written
    always_ff @(posedge ref_clk) begin
        if (wr_done && apb_req.paddr == 8'h10) code_q <= apb_req.pwdata[2:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
    sequence s_rd(lo, hi, pg);
        s_setup ##0 (!apb_req.pwrite && apb_req.paddr >= lo && apb_req.paddr <= hi && page_q == pg);
    endsequence
    property p_ready_next; s_setup |=> pready ##1 !pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("ready not one cycle");
    property p_err; s_setup |=> pslverr == $past(bad_addr) && (!pslverr || prdata == '0); endproperty
    a_err: assert property (p_err) else $error("bad error response");
    property p_compl; s_rd(8'h20, 8'h20, PAGE_IDENT) |=> prdata == {24'h0, COMPLIANCE_LEVEL}; endproperty
    a_compl: assert property (p_compl) else $error("compliance level wrong");
    property p_ident; s_rd(8'h28, 8'h3C, PAGE_IDENT) |=> prdata[7:0] == $past(id_byte); endproperty
    a_ident: assert property (p_ident) else $error("identity byte wrong");
    property p_vendor; s_rd(8'h20, 8'h3C, PAGE_VENDOR) |=> prdata == '0; endproperty
    a_vendor: assert property (p_vendor) else $error("vendor page not zero");
    property p_pwr_wr; wr_done && apb_req.paddr == 8'h10 |-> ##[1:2] self_id_pwr == code_q; endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("power class not taken");
    property p_flags;
        $stable(self_id_pwr) [*3] |-> pwr_self_powered == (self_id_pwr inside {3'h1, 3'h2, 3'h3})
            && pwr_bus_powered == (self_id_pwr inside {3'h4, 3'h6, 3'h7});
    endproperty
    a_flags: assert property (p_flags) else $error("power flags wrong");
    property p_watts;
        $stable(self_id_pwr) [*3] |-> link_extra_watts == (self_id_pwr == PWR_BUS_PLUS_7W ?
            EXTRA_W_7 : self_id_pwr == PWR_BUS_PLUS_3W ? EXTRA_W_3 : EXTRA_W_NONE);
    endproperty
    a_watts: assert property (p_watts) else $error("link watts wrong");
    property p_soft_rst;
        wr_done && apb_req.paddr == 8'h38 && page_q == PAGE_VENDOR && apb_req.pwdata[0]
            |=> soft_reset_pulse ##1 !soft_reset_pulse;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset pulse wrong");
endmodule // phy_id_chk
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the identification and power-class register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import phy_id_pkg::*;
    localparam logic [23:0] OUI = 24'h3C5A96; // arbitrary value
    localparam logic [23:0] PART = 24'h6B1D24; // arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] strap = 3'h0;
    logic allow = 1'b1;
    apb_req_t req;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, self_p, bus_p, srp;
    logic [2:0] self_id_pwr;
    logic [3:0] watts;
    int fail_count = 0, samples_checked = 0, cyc = 0, page = 0, pwr = 0, strap_cur = 0;
    initial forever #25 ref_clk = ~ref_clk;
    phy_id_pages_power_class #(.MAKER_OUI(OUI), .PART_CODE(PART)) i_dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_strap_bit0(strap[0]), .power_strap_bit1(strap[1]), .power_strap_bit2(strap[2]),
        .strap_mode_allow(allow), .self_id_pwr(self_id_pwr), .pwr_self_powered(self_p),
        .pwr_bus_powered(bus_p), .link_extra_watts(watts), .soft_reset_pulse(srp));
    apb_host_model i_host (.ref_clk(ref_clk), .req(req), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // reference model of one register read
    function automatic logic [31:0] exp_rd(input int a);
        if (a > 'h3C || a % 4 != 0 || (a >= 'h20 && page != 1)) return 32'h0;
        if (a == 'h10) return pwr;
        if (a == 'h1C) return page;
        if (a < 'h28) return (a == 'h20) ? 32'h02 : 32'h0;
        return 32'({OUI, PART} >> (8 * (5 - (a - 'h28) / 4))) & 32'hFF;
    endfunction
    task automatic rdc(input int a);
        i_host.xfer(1'b0, a[7:0], 32'h0, rd, err);
        chk("prdata", exp_rd(a), rd);
        chk("pslverr", a > 'h3C || a % 4 != 0, err);
    endtask
    task automatic wr(input int a, input int d);
        i_host.xfer(1'b1, a[7:0], d, rd, err);
        chk("pslverr", a > 'h3C || a % 4 != 0, err);
        if (a == 'h10) pwr = d & 7;
        if (a == 'h1C) page = d & 7;
        if (a == 'h38 && page == 7 && d % 2 == 1) begin
            page = 0;
            pwr = strap_cur;
            @(negedge ref_clk);
            chk("soft_reset_pulse", 32'h1, srp);
            repeat (2) @(posedge ref_clk);
        end
    endtask
    task automatic chk_pwr();
        repeat (2) @(negedge ref_clk);
        chk("self_id_pwr", pwr, self_id_pwr);
        chk("self_powered", pwr inside {1, 2, 3}, self_p);
        chk("bus_powered", pwr inside {4, 6, 7}, bus_p);
        chk("link_watts", pwr == 6 ? 3 : pwr == 7 ? 7 : 0, watts);
        chk("soft_reset_pulse", 32'h0, srp);
    endtask
    // reset held ten cycles with fresh random straps
    task automatic do_reset(input logic al);
        strap <= 3'($urandom % 8);
        allow <= al;
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        strap_cur = al ? int'(strap) : 0;
        page = 0;
        pwr = strap_cur;
    endtask
    initial begin
        void'($urandom(32'hACC508EC));
        do_reset(1'b1);
        chk_pwr();
        rdc('h10);
        rdc('h40);
        rdc('h21);
        wr('h12, 'h6);
        rdc('h10);
        wr('h1C, 1);
        wr('h28, 'hFF);
        for (int a = 'h20; a <= 'h3C; a += 4) begin
            rdc(a);
        end
        wr('h1C, 7);
        wr('h38, 'hFE);
        for (int a = 'h1C; a <= 'h3C; a += 4) begin
            rdc(a);
        end
        for (int c = 0; c < 8; c++) begin
            if (c != 5) begin
                wr('h10, c);
                chk_pwr();
            end
        end
        wr('h10, strap_cur == 0);
        wr('h1C, 7);
        wr('h38, 1);
        chk_pwr();
        rdc('h1C);
        do_reset(1'b0);
        chk_pwr();
        wrap_up();
    end
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            wrap_up();
        end
    end
endmodule // tb_top
bind phy_id_pages_power_class phy_id_chk #(.MAKER_OUI(MAKER_OUI), .PART_CODE(PART_CODE)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .self_id_pwr(self_id_pwr), .pwr_self_powered(pwr_self_powered),
    .pwr_bus_powered(pwr_bus_powered), .link_extra_watts(link_extra_watts),
    .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire
